// *** verilog/cesf_defs.vh ***
// Purpose: Register map, field positions, reset values and thresholds of the CAN error state and filter status block.
// Assumes: 32-bit register port, word indices as offsets.
// Notes: Offsets are register indices; byte address is four times the index.
`ifndef CESF_DEFS_VH
`define CESF_DEFS_VH

// ==========================================================================
// Register indices
`define CESF_IDX_ERR_COUNT 4'h0
`define CESF_IDX_FIFO_PEND 4'h1
`define CESF_IDX_FILT_CTRL 4'h2
`define CESF_IDX_IRQ_STAT 4'h3
`define CESF_IDX_IRQ_MASK 4'h4
`define CESF_IDX_FIFO_IEN 4'h5

// ==========================================================================
// Error count register fields
`define CESF_TXCNT_LSB 8
`define CESF_RXCNT_LSB 0
`define CESF_TX_BUS_OFF_FLAG_BIT 21
`define CESF_TX_PASSIVE_FLAG_BIT 20
`define CESF_RX_PASSIVE_FLAG_BIT 19
`define CESF_TX_WARNING_FLAG_BIT 18
`define CESF_RX_WARNING_FLAG_BIT 17
`define CESF_ANY_WARNING_FLAG_BIT 16

// ==========================================================================
// Filter control fields
`define CESF_F1_ON_BIT 15
`define CESF_F0_ON_BIT 7
`define CESF_FILT_RESET 32'h00000000

// ==========================================================================
// Fault confinement thresholds and steps
`define CESF_WARN_LEVEL 9'h060
`define CESF_PASSIVE_LEVEL 9'h080
`define CESF_BUSOFF_LEVEL 9'h100
`define CESF_TX_ERR_STEP 9'h008
`define CESF_RX_ERR_STEP 9'h001
`define CESF_RX_PRIMARY_STEP 9'h008
`define CESF_RX_RESTART 9'h078

// ==========================================================================
// Interrupt status bits
`define CESF_IRQ_WARN 0
`define CESF_IRQ_PASSIVE 1
`define CESF_IRQ_BUSOFF 2
`define CESF_IRQ_WIDTH 3

`endif

// *** verilog/cesf_fault_counter.v ***
// Purpose: One CAN fault confinement counter with its warning and passive state.
// Assumes: Event inputs are single-cycle pulses.
// Notes: Count is nine bits so that 256 and above can be represented.
`timescale 1ns/10ps
`include "cesf_defs.vh"

module cesf_fault_counter #(
   parameter [8:0] ERR_STEP = 9'h001,
   parameter [8:0] BIG_STEP = 9'h008,
   parameter [8:0] LIMIT = 9'h100
) (
   input wire ref_clk,
   input wire rst,
   input wire err_pulse,
   input wire big_err_pulse,
   input wire ok_pulse,
   input wire restart,
   output reg [8:0] count,
   output wire warning,
   output wire passive
);

   reg [8:0] next_count;

   // ========================================================================
   // Counter update.
   always @* begin
      next_count = count;
      if (restart) begin
         next_count = 9'h000;
      end else if (big_err_pulse) begin
         next_count = (count > LIMIT - BIG_STEP) ? LIMIT : count + BIG_STEP;
      end else if (err_pulse) begin
         next_count = (count > LIMIT - ERR_STEP) ? LIMIT : count + ERR_STEP;
      end else if (ok_pulse && count != 9'h000 && count < LIMIT) begin
         next_count = count - 9'h001;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         count <= 9'h000;
      end else begin
         count <= next_count;
      end
   end

   // ========================================================================
   // Derived states.
   assign passive = (count >= `CESF_PASSIVE_LEVEL);
   assign warning = (count >= `CESF_WARN_LEVEL) && (count < `CESF_PASSIVE_LEVEL);

endmodule

// *** verilog/cesf_filter_slot.v ***
// Purpose: Control fields of one acceptance filter with a write lock.
// Assumes: Field byte is laid out as enable, mask choice, queue choice.
// Notes: Fields other than enable change only while the filter is off.
`timescale 1ns/10ps

module cesf_filter_slot (
   input wire ref_clk,
   input wire rst,
   input wire wr_en,
   input wire [7:0] wr_byte,
   output reg filter_on,
   output reg [1:0] mask_choice,
   output reg [4:0] queue_choice
);

   // ========================================================================
   // Field storage.
   always @(posedge ref_clk) begin
      if (rst) begin
         filter_on <= 1'b0;
         mask_choice <= 2'h0;
         queue_choice <= 5'h00;
      end else if (wr_en) begin
         filter_on <= wr_byte[7];
         if (!filter_on) begin
            mask_choice <= wr_byte[6:5];
            queue_choice <= wr_byte[4:0];
         end
      end
   end

endmodule

// *** verilog/cesf_top.v ***
// Purpose: CAN error state, FIFO pending status and acceptance filter control registers.
// Assumes: Register port with one-cycle strobes; read data in the following cycle.
// Notes: Offsets are word indices; unmapped reads return zero.
// How it works
// - Transmit bus-off flag set while transmit count is 256 or more.
// - Transmit passive flag set while transmit count is 128 or more.
// - Receive passive flag set while receive count is 128 or more.
// - Transmit warning flag set while transmit count is 96 to 127.
// - Receive warning flag set while receive count is 96 to 127.
// - Combined warning flag is the OR of both warning flags.
// - Transmit count in bits 15:8, receive count in 7:0, read only.
// - Error count register bits 31:22 read as zero.
// - One pending bit per FIFO, set when an enabled interrupt is pending.
// - Filter enables sit at bit 15 and bit 7; one enables.
// - Two-bit mask choice picks acceptance mask 0 to 3.
// - Five-bit queue choice picks destination FIFO 0 to 31.
// - Mask and queue fields change only while that filter is disabled.
`timescale 1ns/10ps
`include "cesf_defs.vh"

module cesf_top #(
   parameter NUM_FIFOS = 32
) (
   input wire ref_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,
   input wire tx_error,
   input wire tx_success,
   input wire rx_error,
   input wire rx_primary_error,
   input wire rx_success,
   input wire busoff_recovered,
   input wire [NUM_FIFOS-1:0] fifo_event,
   output wire irq,
   output wire tx_bus_off_flag,
   output wire tx_passive_flag,
   output wire rx_passive_flag,
   output wire tx_warning_flag,
   output wire rx_warning_flag,
   output wire any_warning_flag,
   output wire filter0_on,
   output wire [1:0] filter0_mask_choice,
   output wire [4:0] filter0_queue_choice,
   output wire filter1_on,
   output wire [1:0] filter1_mask_choice,
   output wire [4:0] filter1_queue_choice
);

   wire [8:0] tx_count;
   wire [8:0] rx_count;
   wire tx_passive_raw;
   wire tx_bus_off_raw;
   wire [7:0] tx_fault_count;
   wire [7:0] rx_fault_count;
   reg [NUM_FIFOS-1:0] fifo_raw;
   reg [NUM_FIFOS-1:0] fifo_ien;
   wire [NUM_FIFOS-1:0] queue_irq_pending;
   reg [`CESF_IRQ_WIDTH-1:0] irq_stat;
   reg [`CESF_IRQ_WIDTH-1:0] irq_mask;
   reg [`CESF_IRQ_WIDTH-1:0] prev_state;
   wire [`CESF_IRQ_WIDTH-1:0] cur_state;
   wire [`CESF_IRQ_WIDTH-1:0] state_rise;
   wire [31:0] err_word;
   wire [31:0] filt_word;
   reg [31:0] next_rdata;
   wire wr_filt;
   wire wr_istat;
   wire wr_imask;
   wire wr_ien;

   // ========================================================================
   // Address decode.
   assign wr_filt = reg_write && (reg_addr == `CESF_IDX_FILT_CTRL);
   assign wr_istat = reg_write && (reg_addr == `CESF_IDX_IRQ_STAT);
   assign wr_imask = reg_write && (reg_addr == `CESF_IDX_IRQ_MASK);
   assign wr_ien = reg_write && (reg_addr == `CESF_IDX_FIFO_IEN);

   // ========================================================================
   // Fault counters.
   cesf_fault_counter #(
      .ERR_STEP(`CESF_TX_ERR_STEP),
      .BIG_STEP(`CESF_TX_ERR_STEP),
      .LIMIT(`CESF_BUSOFF_LEVEL)
   ) u_tx_counter (
      .ref_clk(ref_clk),
      .rst(rst),
      .err_pulse(tx_error),
      .big_err_pulse(1'b0),
      .ok_pulse(tx_success),
      .restart(busoff_recovered && tx_bus_off_raw),
      .count(tx_count),
      .warning(tx_warning_flag),
      .passive(tx_passive_raw)
   );

   cesf_fault_counter #(
      .ERR_STEP(`CESF_RX_ERR_STEP),
      .BIG_STEP(`CESF_RX_PRIMARY_STEP),
      .LIMIT(`CESF_PASSIVE_LEVEL)
   ) u_rx_counter (
      .ref_clk(ref_clk),
      .rst(rst),
      .err_pulse(rx_error),
      .big_err_pulse(rx_primary_error),
      .ok_pulse(rx_success),
      .restart(busoff_recovered && tx_bus_off_raw),
      .count(rx_count),
      .warning(rx_warning_flag),
      .passive(rx_passive_flag)
   );

   assign tx_bus_off_raw = (tx_count >= `CESF_BUSOFF_LEVEL);
   assign tx_bus_off_flag = tx_bus_off_raw;
   assign tx_passive_flag = tx_passive_raw;
   assign any_warning_flag = tx_warning_flag | rx_warning_flag;
   assign tx_fault_count = tx_bus_off_raw ? 8'hFF : tx_count[7:0];
   assign rx_fault_count = rx_count[7:0];

   // ========================================================================
   // FIFO pending status.
   always @(posedge ref_clk) begin
      if (rst) begin
         fifo_raw <= {NUM_FIFOS{1'b0}};
         fifo_ien <= {NUM_FIFOS{1'b0}};
      end else begin
         fifo_raw <= fifo_event;
         if (wr_ien) begin
            fifo_ien <= reg_wdata[NUM_FIFOS-1:0];
         end
      end
   end

   assign queue_irq_pending = fifo_raw & fifo_ien;

   // ========================================================================
   // Acceptance filters.
   cesf_filter_slot u_filter0 (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_filt),
      .wr_byte(reg_wdata[7:0]),
      .filter_on(filter0_on),
      .mask_choice(filter0_mask_choice),
      .queue_choice(filter0_queue_choice)
   );

   cesf_filter_slot u_filter1 (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(wr_filt),
      .wr_byte(reg_wdata[15:8]),
      .filter_on(filter1_on),
      .mask_choice(filter1_mask_choice),
      .queue_choice(filter1_queue_choice)
   );

   // ========================================================================
   // Interrupt status and mask.
   assign cur_state = {tx_bus_off_raw, tx_passive_raw | rx_passive_flag, any_warning_flag};
   assign state_rise = cur_state & ~prev_state;

   always @(posedge ref_clk) begin
      if (rst) begin
         prev_state <= {`CESF_IRQ_WIDTH{1'b0}};
         irq_stat <= {`CESF_IRQ_WIDTH{1'b0}};
         irq_mask <= {`CESF_IRQ_WIDTH{1'b0}};
      end else begin
         prev_state <= cur_state;
         if (wr_istat) begin
            irq_stat <= (irq_stat & ~reg_wdata[`CESF_IRQ_WIDTH-1:0]) | state_rise;
         end else begin
            irq_stat <= irq_stat | state_rise;
         end
         if (wr_imask) begin
            irq_mask <= reg_wdata[`CESF_IRQ_WIDTH-1:0];
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ========================================================================
   // Read data.
   assign err_word = {10'h000, tx_bus_off_flag, tx_passive_flag, rx_passive_flag,
                      tx_warning_flag, rx_warning_flag, any_warning_flag,
                      tx_fault_count, rx_fault_count};
   assign filt_word = {16'h0000, filter1_on, filter1_mask_choice, filter1_queue_choice,
                       filter0_on, filter0_mask_choice, filter0_queue_choice};

   always @* begin
      next_rdata = 32'h00000000;
      case (reg_addr)
         `CESF_IDX_ERR_COUNT: next_rdata = err_word;
         `CESF_IDX_FIFO_PEND: next_rdata = queue_irq_pending;
         `CESF_IDX_FILT_CTRL: next_rdata = filt_word;
         `CESF_IDX_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
         `CESF_IDX_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
         `CESF_IDX_FIFO_IEN: next_rdata = fifo_ien;
         default: next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule

// *** testbench/cesf_props.sv ***
// Purpose: Port assertions for the CAN error state and filter block.
// Assumes: Bound into cesf_top.
// Notes: Register indices 0 and 2 are watched.
`timescale 1ns/10ps
module cesf_props (
   input wire ref_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [31:0] reg_rdata,
   input wire irq,
   input wire tx_bus_off_flag,
   input wire tx_passive_flag,
   input wire rx_passive_flag,
   input wire tx_warning_flag,
   input wire rx_warning_flag,
   input wire any_warning_flag,
   input wire filter0_on,
   input wire [1:0] filter0_mask_choice,
   input wire [4:0] filter0_queue_choice,
   input wire filter1_on,
   input wire [1:0] filter1_mask_choice,
   input wire [4:0] filter1_queue_choice
);
   wire [5:0] flg = {tx_bus_off_flag, tx_passive_flag, rx_passive_flag, tx_warning_flag, rx_warning_flag,
      any_warning_flag};
   wire [7:0] f0 = {filter0_on, filter0_mask_choice, filter0_queue_choice};
   wire [7:0] f1 = {filter1_on, filter1_mask_choice, filter1_queue_choice};
   wire fw = reg_write && reg_addr == 4'h2;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ==========
   // Assertions.
   chk_busoff_passive: assert property (tx_bus_off_flag |-> tx_passive_flag && !tx_warning_flag)
      else $error("bus-off without passive");
   chk_tx_warn_band: assert property (tx_warning_flag |-> !tx_passive_flag)
      else $error("tx warning while passive");
   chk_rx_warn_band: assert property (rx_warning_flag |-> !rx_passive_flag)
      else $error("rx warning while passive");
   chk_any_warning: assert property (any_warning_flag == (tx_warning_flag || rx_warning_flag))
      else $error("combined warning wrong");
   chk_error_word: assert property (reg_read && reg_addr == 4'h0 |=> reg_rdata[31:16] == {10'h000, $past(flg)})
      else $error("error word flags wrong");
   chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h00000000)
      else $error("read data outside read");
   chk_filter_read: assert property (reg_read && reg_addr == 4'h2 |=> reg_rdata == {16'h0000, $past(f1), $past(f0)})
      else $error("filter word wrong");
   chk_filter_lock: assert property (fw && filter0_on |=> $stable(f0[6:0]) && f0[7] == $past(reg_wdata[7]))
      else $error("locked filter changed");
   chk_filter_open: assert property (fw && !filter1_on |=> f1 == $past(reg_wdata[15:8]))
      else $error("open filter not written");
   cover property (tx_bus_off_flag);
   cover property (fw && filter0_on);
   cover property (irq);
endmodule

bind cesf_top cesf_props u_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
   .tx_bus_off_flag(tx_bus_off_flag), .tx_passive_flag(tx_passive_flag), .rx_passive_flag(rx_passive_flag),
   .tx_warning_flag(tx_warning_flag), .rx_warning_flag(rx_warning_flag), .any_warning_flag(any_warning_flag),
   .filter0_on(filter0_on), .filter0_mask_choice(filter0_mask_choice), .filter0_queue_choice(filter0_queue_choice),
   .filter1_on(filter1_on), .filter1_mask_choice(filter1_mask_choice), .filter1_queue_choice(filter1_queue_choice));

// *** testbench/cesf_can_node.sv ***
// Purpose: Other CAN nodes seen as fault confinement events.
// Assumes: One event per strobe, one cycle long.
// Notes: Codes 0 to 5 pick the event line.
`timescale 1ns/10ps
module cesf_can_node (
   input wire [2:0] ev_code,
   input wire ev_go,
   output wire tx_error,
   output wire tx_success,
   output wire rx_error,
   output wire rx_primary_error,
   output wire rx_success,
   output wire busoff_recovered
);
   // ==========
   // Event decode.
   assign tx_error = ev_go && ev_code == 3'h0;
   assign tx_success = ev_go && ev_code == 3'h1;
   assign rx_error = ev_go && ev_code == 3'h2;
   assign rx_primary_error = ev_go && ev_code == 3'h3;
   assign rx_success = ev_go && ev_code == 3'h4;
   assign busoff_recovered = ev_go && ev_code == 3'h5;
endmodule

// *** testbench/cesf_top_tb_top.sv ***
// Purpose: Self-checking bench for cesf_top.
// Assumes: Integer model of both counters and the filter fields.
// Notes: Random events come from an xorshift sequence.
`timescale 1ns/10ps
module cesf_top_tb_top;
   reg ref_clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] reg_addr = 4'h0;
   reg [31:0] reg_wdata = 32'h00000000;
   reg reg_write = 1'b0;
   reg reg_read = 1'b0;
   reg [2:0] ev_code = 3'h0;
   reg ev_go = 1'b0;
   reg [31:0] fifo_event = 32'h00000000;
   reg [31:0] seed = 32'h0000B988;
   reg [31:0] d, e;
   reg [2:0] code, stat, prev, now;
   reg [15:0] fm;
   wire [31:0] reg_rdata;
   wire [5:0] flg;
   wire [15:0] flt;
   wire irq, t_err, t_ok, r_err, r_big, r_ok, b_rec;
   integer mismatches = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer tx = 0;
   integer rx = 0;
   integer i;
   cesf_can_node nodes (.ev_code(ev_code), .ev_go(ev_go), .tx_error(t_err), .tx_success(t_ok), .rx_error(r_err),
      .rx_primary_error(r_big), .rx_success(r_ok), .busoff_recovered(b_rec));
   cesf_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_error(t_err), .tx_success(t_ok), .rx_error(r_err),
      .rx_primary_error(r_big), .rx_success(r_ok), .busoff_recovered(b_rec), .fifo_event(fifo_event), .irq(irq),
      .tx_bus_off_flag(flg[5]), .tx_passive_flag(flg[4]), .rx_passive_flag(flg[3]), .tx_warning_flag(flg[2]),
      .rx_warning_flag(flg[1]), .any_warning_flag(flg[0]), .filter0_on(flt[7]), .filter0_mask_choice(flt[6:5]),
      .filter0_queue_choice(flt[4:0]), .filter1_on(flt[15]), .filter1_mask_choice(flt[14:13]),
      .filter1_queue_choice(flt[12:8]));
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [31:0] ew(input integer t, input integer q);
      reg tw, rw;
      begin
         tw = t >= 96 && t < 128;
         rw = q >= 96 && q < 128;
         ew = {10'h000, t >= 256, t >= 128, q >= 128, tw, rw, tw | rw, (t >= 256) ? 8'hFF : t[7:0], q[7:0]};
      end
   endfunction
   task chk(input [31:0] exp, input [31:0] got, input [79:0] nm);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] v);
      begin
         @(posedge ref_clk);
         reg_write <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge ref_clk);
         reg_write <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, output [31:0] v);
      begin
         @(posedge ref_clk);
         reg_read <= 1'b1;
         reg_addr <= a;
         @(posedge ref_clk);
         reg_read <= 1'b0;
         #1 v = reg_rdata;
      end
   endtask
   task ev(input [2:0] c);
      begin
         @(posedge ref_clk);
         ev_code <= c;
         ev_go <= 1'b1;
         @(posedge ref_clk);
         ev_go <= 1'b0;
      end
   endtask
   task test_done;
      begin
         $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
         rd(i[3:0] ^ {i[2], 3'h0}, d);
         chk(32'h00000000, d, "reset");
      end
      wr(4'h4, 32'h00000007);
      rd(4'h4, d);
      chk(32'h00000007, d, "irqmask_rd");
      stat = 3'h0;
      prev = 3'h0;
      for (i = 0; i < 300; i = i + 1) begin
         seed = xs(seed);
         e = seed % 6;
         code = e[2:0];
         if (tx >= 256) code = 3'h5;
         else if (code == 3'h4 && rx >= 128) code = 3'h2;
         ev(code);
         case (code)
            3'h0: tx = (tx + 8 > 256) ? 256 : tx + 8;
            3'h1: if (tx > 0) tx = tx - 1;
            3'h2: rx = (rx + 1 > 128) ? 128 : rx + 1;
            3'h3: rx = (rx + 8 > 128) ? 128 : rx + 8;
            3'h4: if (rx > 0) rx = rx - 1;
            default: if (tx >= 256) begin
               tx = 0;
               rx = 0;
            end
         endcase
         now = {tx >= 256, tx >= 128 || rx >= 128, (tx >= 96 && tx < 128) || (rx >= 96 && rx < 128)};
         stat = stat | (now & ~prev);
         prev = now;
         rd(4'h0, d);
         e = ew(tx, rx);
         chk(e, d, "errword");
         chk(e[21:16], flg, "flags");
         chk(|stat, irq, "irq");
      end
      rd(4'h3, d);
      chk(stat, d, "irqstat");
      wr(4'h4, 32'h00000000);
      #1 chk(0, irq, "irqmask");
      wr(4'h3, {29'h0, stat});
      wr(4'h4, 32'h00000007);
      rd(4'h3, d);
      chk(0, d | irq, "irqclear");
      for (i = 0; i < 4; i = i + 1) begin
         seed = xs(seed);
         e = seed;
         seed = xs(seed);
         wr(4'h5, e);
         fifo_event <= seed;
         repeat (3) @(posedge ref_clk);
         rd(4'h5, d);
         chk(e, d, "fifo_ien");
         rd(4'h1, d);
         chk(e & seed, d, "pending");
         wr(4'h1, ~d);
         wr(4'h0, 32'hFFFFFFFF);
         rd(4'h1, e);
         chk(d, e, "pend_ro");
         rd(4'h0, e);
         chk(ew(tx, rx), e, "err_ro");
      end
      fm = 16'h0000;
      for (i = 0; i < 24; i = i + 1) begin
         seed = xs(seed);
         wr(4'h2, seed);
         if (!fm[7]) fm[6:0] = seed[6:0];
         if (!fm[15]) fm[14:8] = seed[14:8];
         fm[7] = seed[7];
         fm[15] = seed[15];
         rd(4'h2, d);
         chk(fm, d, "filter");
         chk(fm, flt, "filt_pins");
      end
      test_done;
   end
endmodule
